/* File: common/mtc_pkg.sv */
// Constants for the motor tuning configuration register bank.
// Assumes a 40 MHz system clock and an 8-bit register address from the serial host.
package mtc_pkg;

  // Register word and address widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] BEMF_ADVANCE_CONFIG_OFS  = 8'h91;
  localparam logic [ADDR_W-1:0] STARTUP_BRAKE_CONFIG_OFS = 8'h92;

  // Values after reset
  localparam logic [DATA_W-1:0] BEMF_ADVANCE_CONFIG_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] STARTUP_BRAKE_CONFIG_RST = 16'h0000;

  // Writable bits of the back-EMF and advance word; bit 15 is reserved
  localparam logic [DATA_W-1:0] BEMF_ADVANCE_WR_MASK = 16'h7FFF;

  // Field positions in the back-EMF and advance word
  localparam int BEMF_SHIFT_LSB    = 12;
  localparam int BEMF_MANT_LSB     = 8;
  localparam int ADV_MODE_BIT      = 7;
  localparam int ADV_SHIFT_LSB     = 4;
  localparam int ADV_MANT_LSB      = 0;

  // Field positions in the start-up and brake word
  localparam int STAT_THR_LSB      = 14;
  localparam int BRK_CUR_BIT       = 13;
  localparam int HYST_BIT          = 12;
  localparam int SPEED_DET_EN_BIT  = 11;
  localparam int REV_EN_BIT        = 10;
  localparam int REV_THR_LSB       = 8;
  localparam int OL_CUR_LSB        = 6;
  localparam int OL_RAMP_LSB       = 3;
  localparam int BRK_DUR_LSB       = 0;

  // Width of a mantissa shifted by up to seven places
  localparam int SCALED_W = 11;

  // Clock rate and time figures
  localparam int unsigned CLK_FREQ_KHZ     = 40000;
  localparam int unsigned STAT_WIN_MIN_MS  = 80;
  localparam int unsigned BRAKE_MAX_MS     = 2700;
  localparam int unsigned STAT_WIN_MIN_CYCLES = STAT_WIN_MIN_MS * CLK_FREQ_KHZ;
  localparam int unsigned BRAKE_MAX_CYCLES    = BRAKE_MAX_MS * CLK_FREQ_KHZ;

  // Widths of the cycle-count outputs
  localparam int STAT_WIN_W = 25;
  localparam int BRAKE_W    = 27;

  // Reset synchroniser length
  localparam int RST_SYNC_STAGES = 2;

endpackage : mtc_pkg

/* File: logic/mtc_shift_scale.sv */
// Mantissa-and-shift expander for packed configuration constants.
// Assumes a four-bit mantissa and a three-bit shift count; purely combinational.
`timescale 1ns/1ps
module mtc_shift_scale
  import mtc_pkg::*;
(
  input  wire logic [3:0]          mantissa,
  input  wire logic [2:0]          shiftCount,
  output logic      [SCALED_W-1:0] scaled
);

  // Widen first so no bit falls off the top
  always_comb begin
    scaled = {{(SCALED_W-4){1'b0}}, mantissa} << shiftCount;
  end

endmodule : mtc_shift_scale

/* File: logic/mtc_config_regs.sv */
// Two configuration words of a sensorless motor controller, with field decode.
// Assumes a serial register host that presents single-cycle write and read strobes
// on this clock, and a motor control core that samples the decoded outputs.
// Operation
// (R1) Host leaves reserved top bit untouched.
// (R2) Back-EMF constant is mantissa shifted left.
// (R3) Advance mode: fixed or supply-scaled.
// (R4) Advance time is mantissa shifted left.
// (R5) Stationary threshold picks 80-640 ms window.
// (R6) Hysteresis bit picks 20 or 40 mV.
// (R7) Speed detection runs only when enabled.
// (R8) Reverse drive allowed only when enabled.
// (R9) Reverse threshold code picks 6.3-51 Hz.
// (R10) Current code sets open-loop and align current.
// (R11) Brake code zero disables; else halving durations.
// (R12) Decoded fields update at edge after write.
// (R13) Reset clears every writable field.
`timescale 1ns/1ps
module mtc_config_regs
  import mtc_pkg::*;
#(
  parameter int unsigned STAT_WIN_CYCLES = STAT_WIN_MIN_CYCLES, // Shortest stationary window
  parameter int unsigned BRAKE_CYCLES    = BRAKE_MAX_CYCLES     // Longest brake duration
)
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Register host side
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWrData,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  output logic      [DATA_W-1:0]     regRdData,
  output logic                       regRdAck,
  // Decoded settings toward the motor control core
  output logic      [SCALED_W-1:0]   bemfConstant,
  output logic      [SCALED_W-1:0]   advanceTime,
  output logic                       advanceModeSel,
  output logic      [1:0]            stationarySpeedThreshold,
  output logic      [STAT_WIN_W-1:0] stationaryWindowCycles,
  output logic                       brakeCurrentThresholdSel,
  output logic      [5:0]            brakeCurrentThresholdMa,
  output logic                       comparatorHysteresisSel,
  output logic      [5:0]            comparatorHysteresisMv,
  output logic                       speedDetectEnable,
  output logic                       reverseDriveEnable,
  output logic      [1:0]            reverseDriveThreshold,
  output logic      [9:0]            reverseDriveThresholdDeciHz,
  output logic      [1:0]            openloopCurrentSel,
  output logic      [10:0]           openloopCurrentMa,
  output logic      [10:0]           alignCurrentMa,
  output logic      [2:0]            openloopCurrentRamp,
  output logic      [2:0]            brakeDurationSel,
  output logic                       brakeActive,
  output logic      [BRAKE_W-1:0]    brakeDurationCycles
);

  // Reset synchroniser chain
  logic [RST_SYNC_STAGES-1:0] rstSync;
  // Released reset used by everything else
  logic                       rstSync_n;

  // Stored configuration words
  logic [DATA_W-1:0] bemfAdvanceConfig;
  logic [DATA_W-1:0] startupBrakeConfig;
  // Words as they will be after this edge
  logic [DATA_W-1:0] next_bemfAdvanceConfig;
  logic [DATA_W-1:0] next_startupBrakeConfig;

  // Address hits
  logic hitBemf;
  logic hitBrake;

  // Shifted products from the next words
  logic [SCALED_W-1:0] next_bemfConstant;
  logic [SCALED_W-1:0] next_advanceTime;

  // Open-loop current in mA for a two-bit code
  function automatic logic [10:0] olCurrentMa(input logic [1:0] code);
    case (code)
      2'h0:    olCurrentMa = 11'h0C8;  // 0.2 A
      2'h1:    olCurrentMa = 11'h190;  // 0.4 A
      2'h2:    olCurrentMa = 11'h320;  // 0.8 A
      default: olCurrentMa = 11'h640;  // 1.6 A
    endcase
  endfunction : olCurrentMa

  // Align current in mA for the same code
  function automatic logic [10:0] alCurrentMa(input logic [1:0] code);
    case (code)
      2'h0:    alCurrentMa = 11'h096;  // 0.15 A
      2'h1:    alCurrentMa = 11'h12C;  // 0.3 A
      2'h2:    alCurrentMa = 11'h258;  // 0.6 A
      default: alCurrentMa = 11'h4B0;  // 1.2 A
    endcase
  endfunction : alCurrentMa

  // Reverse threshold in tenths of a hertz
  function automatic logic [9:0] revThrDeciHz(input logic [1:0] code);
    case (code)
      2'h0:    revThrDeciHz = 10'h03F;  // 6.3 Hz
      2'h1:    revThrDeciHz = 10'h082;  // 13 Hz
      2'h2:    revThrDeciHz = 10'h104;  // 26 Hz
      default: revThrDeciHz = 10'h1FE;  // 51 Hz
    endcase
  endfunction : revThrDeciHz

  // Stationary window doubles per code step, 80 ms at code zero
  function automatic logic [STAT_WIN_W-1:0] statWindow(input logic [1:0] code);
    logic [STAT_WIN_W-1:0] base;
    base       = STAT_WIN_W'(STAT_WIN_CYCLES);
    statWindow = base << code;
  endfunction : statWindow

  // Brake time halves per code step; zero means no braking
  function automatic logic [BRAKE_W-1:0] brakeWindow(input logic [2:0] code);
    logic [BRAKE_W-1:0] base;
    base = BRAKE_W'(BRAKE_CYCLES);
    if (code == 3'h0) begin
      brakeWindow = '0;
    end else begin
      brakeWindow = base >> (code - 3'h1);
    end
  endfunction : brakeWindow

  // Hold reset until two clean edges after release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= '0;
    end else begin
      rstSync <= {rstSync[RST_SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rstSync_n = rstSync[RST_SYNC_STAGES-1];

  // Address decode
  always_comb begin
    hitBemf  = (regAddr == BEMF_ADVANCE_CONFIG_OFS);
    hitBrake = (regAddr == STARTUP_BRAKE_CONFIG_OFS);
  end

  // Next word values; the reserved top bit never takes host data
  always_comb begin
    next_bemfAdvanceConfig  = bemfAdvanceConfig;
    next_startupBrakeConfig = startupBrakeConfig;
    if (regWrEn && hitBemf) begin
      next_bemfAdvanceConfig = regWrData & BEMF_ADVANCE_WR_MASK; // R1
    end
    if (regWrEn && hitBrake) begin
      next_startupBrakeConfig = regWrData;
    end
  end

  // Back-EMF constant from mantissa and shift count
  mtc_shift_scale uBemfScale (
    .mantissa   (next_bemfAdvanceConfig[BEMF_MANT_LSB +: 4]),   // R2
    .shiftCount (next_bemfAdvanceConfig[BEMF_SHIFT_LSB +: 3]),  // R2
    .scaled     (next_bemfConstant)
  );

  // Commutation advance time from mantissa and shift count
  mtc_shift_scale uAdvScale (
    .mantissa   (next_bemfAdvanceConfig[ADV_MANT_LSB +: 4]),    // R4
    .shiftCount (next_bemfAdvanceConfig[ADV_SHIFT_LSB +: 3]),   // R4
    .scaled     (next_advanceTime)
  );

  // Word storage; decode is taken from the next value so the core
  // sees a write on the very edge that stores it
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bemfAdvanceConfig  <= BEMF_ADVANCE_CONFIG_RST;  // R13
      startupBrakeConfig <= STARTUP_BRAKE_CONFIG_RST; // R13
    end else begin
      bemfAdvanceConfig  <= next_bemfAdvanceConfig;   // R12
      startupBrakeConfig <= next_startupBrakeConfig;  // R12
    end
  end

  // Back-EMF and advance settings
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bemfConstant   <= '0;
      advanceTime    <= '0;
      advanceModeSel <= 1'b0;
    end else begin
      bemfConstant   <= next_bemfConstant;                      // R2
      advanceTime    <= next_advanceTime;                       // R4
      // Zero holds advance fixed, one asks the core to scale by BEMF/supply
      advanceModeSel <= next_bemfAdvanceConfig[ADV_MODE_BIT];   // R3
    end
  end

  // Initial speed detection and comparator settings
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stationarySpeedThreshold <= 2'h0;
      stationaryWindowCycles   <= '0;
      speedDetectEnable        <= 1'b0;
      comparatorHysteresisSel  <= 1'b0;
      comparatorHysteresisMv   <= 6'h00;
    end else begin
      stationarySpeedThreshold <= next_startupBrakeConfig[STAT_THR_LSB +: 2];  // R5
      stationaryWindowCycles   <= statWindow(next_startupBrakeConfig[STAT_THR_LSB +: 2]); // R5
      // Core skips detection entirely while this is low
      speedDetectEnable        <= next_startupBrakeConfig[SPEED_DET_EN_BIT];   // R7
      comparatorHysteresisSel  <= next_startupBrakeConfig[HYST_BIT];           // R6
      if (next_startupBrakeConfig[HYST_BIT]) begin
        comparatorHysteresisMv <= 6'h28; // R6
      end else begin
        comparatorHysteresisMv <= 6'h14; // R6
      end
    end
  end

  // Reverse drive settings
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      reverseDriveEnable          <= 1'b0;
      reverseDriveThreshold       <= 2'h0;
      reverseDriveThresholdDeciHz <= 10'h000;
    end else begin
      reverseDriveEnable          <= next_startupBrakeConfig[REV_EN_BIT];        // R8
      reverseDriveThreshold       <= next_startupBrakeConfig[REV_THR_LSB +: 2];  // R9
      reverseDriveThresholdDeciHz <= revThrDeciHz(next_startupBrakeConfig[REV_THR_LSB +: 2]); // R9
    end
  end

  // Open-loop and align current settings
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      openloopCurrentSel  <= 2'h0;
      openloopCurrentMa   <= 11'h000;
      alignCurrentMa      <= 11'h000;
      openloopCurrentRamp <= 3'h0;
    end else begin
      openloopCurrentSel  <= next_startupBrakeConfig[OL_CUR_LSB +: 2];              // R10
      openloopCurrentMa   <= olCurrentMa(next_startupBrakeConfig[OL_CUR_LSB +: 2]); // R10
      alignCurrentMa      <= alCurrentMa(next_startupBrakeConfig[OL_CUR_LSB +: 2]); // R10
      // Ramp code only; code zero is fastest, the core owns the slope table
      openloopCurrentRamp <= next_startupBrakeConfig[OL_RAMP_LSB +: 3];             // R10
    end
  end

  // Brake settings
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      brakeDurationSel         <= 3'h0;
      brakeActive              <= 1'b0;
      brakeDurationCycles      <= '0;
      brakeCurrentThresholdSel <= 1'b0;
      brakeCurrentThresholdMa  <= 6'h00;
    end else begin
      brakeDurationSel         <= next_startupBrakeConfig[BRK_DUR_LSB +: 3];               // R11
      brakeActive              <= (next_startupBrakeConfig[BRK_DUR_LSB +: 3] != 3'h0);     // R11
      brakeDurationCycles      <= brakeWindow(next_startupBrakeConfig[BRK_DUR_LSB +: 3]);  // R11
      brakeCurrentThresholdSel <= next_startupBrakeConfig[BRK_CUR_BIT];                    // R11
      if (next_startupBrakeConfig[BRK_CUR_BIT]) begin
        brakeCurrentThresholdMa <= 6'h30; // R11
      end else begin
        brakeCurrentThresholdMa <= 6'h18; // R11
      end
    end
  end

  // Read port; one cycle of latency, unmapped addresses answer zero.
  // Reserved bit always reads zero because it is never stored.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdData <= '0;
      regRdAck  <= 1'b0;
    end else begin
      regRdAck <= regRdEn;
      if (regRdEn && hitBemf) begin
        regRdData <= bemfAdvanceConfig; // R1
      end else if (regRdEn && hitBrake) begin
        regRdData <= startupBrakeConfig;
      end else if (regRdEn) begin
        regRdData <= '0;
      end
    end
  end

endmodule : mtc_config_regs

/* File: verif/mtc_config_regs_checker.sv */
// Concurrent checks on the two configuration words and their decoded fields.
// Assumes binding into mtc_config_regs; one clock, active-low asynchronous reset.
`timescale 1ns/1ps
module mtc_config_regs_checker
  import mtc_pkg::*;
#(
  parameter int unsigned STAT_WIN_CYCLES = 10, // Shortest stationary window
  parameter int unsigned BRAKE_CYCLES    = 64  // Longest brake duration
)
(
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic [ADDR_W-1:0]     regAddr,
  input wire logic [DATA_W-1:0]     regWrData,
  input wire logic                  regWrEn,
  input wire logic                  regRdEn,
  input wire logic [DATA_W-1:0]     regRdData,
  input wire logic                  regRdAck,
  input wire logic [SCALED_W-1:0]   bemfConstant,
  input wire logic [SCALED_W-1:0]   advanceTime,
  input wire logic                  advanceModeSel,
  input wire logic [STAT_WIN_W-1:0] stationaryWindowCycles,
  input wire logic [5:0]            comparatorHysteresisMv,
  input wire logic                  speedDetectEnable,
  input wire logic                  reverseDriveEnable,
  input wire logic [2:0]            brakeDurationSel,
  input wire logic                  brakeActive,
  input wire logic [BRAKE_W-1:0]    brakeDurationCycles
);
  // Writes that land on each word
  wire logic wrA = regWrEn && (regAddr == BEMF_ADVANCE_CONFIG_OFS);
  wire logic wrB = regWrEn && (regAddr == STARTUP_BRAKE_CONFIG_OFS);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Read answer is a one-cycle pulse tied to its strobe
  ack_follows_a: assert property (regRdEn |=> regRdAck) else $error("read ack missing");
  ack_spurious_a: assert property (!regRdEn |=> !regRdAck) else $error("read ack unasked");
  rsvd_zero_a: assert property (
    regRdEn && regAddr == BEMF_ADVANCE_CONFIG_OFS |=> regRdData[15] == 1'b0)
    else $error("reserved bit read high");
  // Decoded fields follow the fields of the written word
  bemf_const_a: assert property (
    wrA |=> bemfConstant == (SCALED_W'($past(regWrData[11:8])) << $past(regWrData[14:12])))
    else $error("back-emf constant wrong");
  adv_time_a: assert property (
    wrA |=> advanceTime == (SCALED_W'($past(regWrData[3:0])) << $past(regWrData[6:4])))
    else $error("advance time wrong");
  adv_mode_a: assert property (wrA |=> advanceModeSel == $past(regWrData[7]))
    else $error("advance mode wrong");
  stat_win_a: assert property (
    wrB |=> stationaryWindowCycles == (STAT_WIN_W'(STAT_WIN_CYCLES) << $past(regWrData[15:14])))
    else $error("stationary window wrong");
  hyst_mv_a: assert property (
    wrB |=> comparatorHysteresisMv == ($past(regWrData[12]) ? 6'h28 : 6'h14))
    else $error("hysteresis wrong");
  detect_en_a: assert property (wrB |=> speedDetectEnable == $past(regWrData[11]))
    else $error("speed detect enable wrong");
  reverse_en_a: assert property (wrB |=> reverseDriveEnable == $past(regWrData[10]))
    else $error("reverse enable wrong");
  brake_len_a: assert property (
    wrB |=> brakeActive == ($past(regWrData[2:0]) != 3'h0) && brakeDurationCycles ==
      ($past(regWrData[2:0]) == 3'h0 ? '0 : BRAKE_W'(BRAKE_CYCLES >> ($past(regWrData[2:0]) - 3'h1))))
    else $error("brake decode wrong");
  brake_hold_a: assert property (!wrB |=> $stable(brakeDurationSel))
    else $error("brake field moved without write");

  // Main scenarios reached
  cover property (wrB && regWrData[2:0] == 3'h7);
  cover property (wrA && regRdEn);
  cover property (regRdAck);
endmodule : mtc_config_regs_checker

bind mtc_config_regs mtc_config_regs_checker #(
  .STAT_WIN_CYCLES(STAT_WIN_CYCLES),
  .BRAKE_CYCLES   (BRAKE_CYCLES)
) chk_u (.*);

/* File: verif/mtc_host_model.sv */
// Serial register host model: single-cycle write and read strobes.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module mtc_host_model
  import mtc_pkg::*;
(
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] regAddr,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regWrEn,
  output logic                   regRdEn
);
  // Quiet bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // One access held through the taking edge; back to back allowed
  task automatic op(input logic we, input logic re, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    regAddr = a;
    regWrData = (a == BEMF_ADVANCE_CONFIG_OFS) ? (d & BEMF_ADVANCE_WR_MASK) : d;
    regWrEn = we;
    regRdEn = re;
    @(posedge clk);
    #1;
  endtask : op

  // Released buses show stale garbage, never the last value
  task automatic idle();
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
    @(posedge clk);
    #1;
  endtask : idle
endmodule : mtc_host_model

/* File: verif/motor_tuning_config_regs_bench.sv */
// Self-checking bench for the motor tuning configuration registers.
// Assumes the host model drives requests; reads are scored from a queue.
`timescale 1ns/1ps
module motor_tuning_config_regs_bench;
  import mtc_pkg::*;
  localparam int unsigned STW = 10; // Short stationary window for sim
  localparam int unsigned BRK = 64; // Short brake time for sim
  localparam logic [31:0] REV_HZ [4] = '{32'h3F, 32'h82, 32'h104, 32'h1FE};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, sa, sb;
  logic regWrEn, regRdEn, regRdAck, advanceModeSel, brakeCurrentThresholdSel;
  logic comparatorHysteresisSel, speedDetectEnable, reverseDriveEnable, brakeActive;
  logic [SCALED_W-1:0] bemfConstant, advanceTime;
  logic [1:0] stationarySpeedThreshold, reverseDriveThreshold, openloopCurrentSel;
  logic [2:0] openloopCurrentRamp, brakeDurationSel, k;
  logic [5:0] brakeCurrentThresholdMa, comparatorHysteresisMv;
  logic [9:0] reverseDriveThresholdDeciHz;
  logic [10:0] openloopCurrentMa, alignCurrentMa;
  logic [STAT_WIN_W-1:0] stationaryWindowCycles;
  logic [BRAKE_W-1:0] brakeDurationCycles;
  logic [15:0] expQ[$]; // Expected read words, oldest first
  integer seed, r, fails = 0, n_compared = 0;

  always #12.5 clk = ~clk;
  mtc_config_regs #(.STAT_WIN_CYCLES(STW), .BRAKE_CYCLES(BRK)) dut_u (.*);
  mtc_host_model host_u (.*);

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Write through the host and track the stored words
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_u.op(1'b1, 1'b0, a, d);
    if (a == BEMF_ADVANCE_CONFIG_OFS) sa = d & 16'h7FFF;
    if (a == STARTUP_BRAKE_CONFIG_OFS) sb = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host_u.op(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  // Decoded outputs against values worked out from the two words
  task automatic decode(input logic [15:0] a, input logic [15:0] b);
    check("bemfConstant", bemfConstant, 32'(a[11:8]) << a[14:12]);
    check("advanceModeSel", advanceModeSel, a[7]);
    check("advanceTime", advanceTime, 32'(a[3:0]) << a[6:4]);
    check("stationaryWindowCycles", stationaryWindowCycles, STW << b[15:14]);
    check("comparatorHysteresisMv", comparatorHysteresisMv, b[12] ? 32'h28 : 32'h14);
    check("speedDetectEnable", speedDetectEnable, b[11]);
    check("reverseDriveEnable", reverseDriveEnable, b[10]);
    check("reverseDeciHz", reverseDriveThresholdDeciHz, REV_HZ[b[9:8]]);
    check("openloopCurrentMa", openloopCurrentMa, 32'hC8 << b[7:6]);
    check("alignCurrentMa", alignCurrentMa, 32'h96 << b[7:6]);
    check("openloopCurrentRamp", openloopCurrentRamp, b[5:3]);
    check("brakeCurrentMa", brakeCurrentThresholdMa, b[13] ? 32'h30 : 32'h18);
    check("brakeActive", brakeActive, b[2:0] != 3'h0);
    check("brakeCycles", brakeDurationCycles, b[2:0] == 3'h0 ? 32'h0 : BRK >> (b[2:0] - 3'h1));
    check("stationarySpeedThreshold", stationarySpeedThreshold, b[15:14]);
    check("brakeCurrentThresholdSel", brakeCurrentThresholdSel, b[13]);
    check("comparatorHysteresisSel", comparatorHysteresisSel, b[12]);
    check("reverseDriveThreshold", reverseDriveThreshold, b[9:8]);
    check("openloopCurrentSel", openloopCurrentSel, b[7:6]);
    check("brakeDurationSel", brakeDurationSel, b[2:0]);
  endtask : decode

  // Scoreboard: each read answer takes the oldest note
  always @(posedge clk) begin
    if (regRdAck === 1'b1) begin
      if (expQ.size() == 0) check("unexpected ack", 32'h1, 32'h0);
      else check("regRdData", regRdData, expQ.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    seed = 32'hE1EDD01B;
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (int p = 0; p < 2; p++) begin
      sa = 16'h0000;
      sb = 16'h0000;
      rd(BEMF_ADVANCE_CONFIG_OFS, 16'h0000);
      rd(STARTUP_BRAKE_CONFIG_OFS, 16'h0000);
      host_u.idle();
      decode(sa, sb);
      $display("test reset_values pass %0d done", p);
      if (p == 1) break;
      // Every code of the multi-bit start-up and brake fields, random back-EMF word; back-to-back writes and reads
      for (int i = 0; i < 8; i++) begin
        k = i[2:0];
        r = $random(seed);
        wr(BEMF_ADVANCE_CONFIG_OFS, r[15:0]);
        wr(STARTUP_BRAKE_CONFIG_OFS, {k[1:0], r[29:26], k[1:0], k[1:0], k, k});
        decode(sa, sb);
        rd(BEMF_ADVANCE_CONFIG_OFS, sa);
        rd(STARTUP_BRAKE_CONFIG_OFS, sb);
      end
      $display("test field_codes done");
      // Unmapped place, then write and read of one word in one cycle
      wr(8'h93, 16'hFFFF);
      rd(8'h93, 16'h0000);
      expQ.push_back(sb);
      host_u.op(1'b1, 1'b1, STARTUP_BRAKE_CONFIG_OFS, ~sb);
      sb = ~sb;
      host_u.idle();
      decode(sa, sb);
      $display("test unmapped_and_overlap done");
      arst_n = 1'b0;
      @(posedge clk);
      #1;
      check("brakeActiveInReset", brakeActive, 1'b0);
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
    end
    for (int w = 0; w < 8 && expQ.size() > 0; w++) @(posedge clk);
    if (expQ.size() != 0) fails++;
    conclude();
  end
endmodule : motor_tuning_config_regs_bench
